// File: testbench/testbench.sv
`timescale 1ns/10ps
module testbench;
    import toil_pkg::*;
    logic clk = 0;
    logic arst_n = 0;
    toil_stage_s stage = '0;
    logic pwr = 1, fault = 0, in1 = 0, in2 = 0, mode = 0, aux = 0;
    toil_led_s led;
    toil_contact_s ct;
    logic coil, flag, any;
    int errors = 0;
    int tests_run = 0;
    int cp, cl, fp, fl, flips;
    logic prev;
    initial forever #50 clk = ~clk;
    // Short counts keep the run brief
    toil_trip_output #(.FLASH_CYC(4), .PULSE_CYC(10), .C1_CYC(20), .LATCH_CYCLES(50)) u_dut (
        .I_SYS_CLK(clk), .I_ARST_N(arst_n), .I_STAGE(stage), .I_CPU_POWERED(pwr), .I_HW_FAULT(fault),
        .I_LOGIC_INPUT_ONE(in1), .I_LOGIC_INPUT_TWO(in2), .I_SWITCH_IO_CONFIG_MODE(mode),
        .I_SWITCH_INPUT_ONE_AUX(aux), .O_LED(led), .O_TRIP_COIL(coil), .O_FLAG_IND(flag),
        .O_CONTACT(ct), .O_ANY_TRIP(any));
    toil_coil_model u_load (.clk(clk), .coil(coil), .flag(flag), .coil_pulses(cp), .coil_len(cl),
        .flag_pulses(fp), .flag_len(fl));
    task cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
        end
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        #1ms;
        errors++;
        tally_and_finish();
    end
    initial begin
        repeat (5) @(posedge clk);
        chk("reset outputs", 32'h0, {any, ct, coil, flag});
        arst_n <= 1'b1;
        cyc(4);
        chk("healthy", 32'h1, led.healthy_led);
        @(posedge clk) fault <= 1'b1;
        cyc(2);
        chk("healthy fault", 32'h0, led.healthy_led);
        @(posedge clk) fault <= 1'b0;
        pwr <= 1'b0;
        cyc(2);
        chk("healthy unpowered", 32'h0, led.healthy_led);
        @(posedge clk) pwr <= 1'b1;
        stage.start <= 4'h2;
        cyc(2);
        chk("contact four", 32'h1, ct.contact_four);
        flips = 0;
        prev = led.stage_led[1];
        repeat (16) begin
            cyc(1);
            if (led.stage_led[1] !== prev) flips++;
            prev = led.stage_led[1];
        end
        chk("flash toggles", 32'd4, flips);
        @(posedge clk) stage.start <= 4'h0;
        cyc(2);
        chk("contact four off", 32'h0, ct.contact_four);
        @(posedge clk) stage.trip[0] <= 1'b1;
        cyc(1);
        chk("trip outputs", 32'h1F, {any, led.stage_led[0], ct.contact_one, ct.contact_two,
            ct.contact_three});
        cyc(24);
        chk("contact one pulse", 32'h0, ct.contact_one);
        chk("contact two held", 32'h1, ct.contact_two);
        chk("coil pulses", 32'h2_0A, {cp[23:0], cl[7:0]});
        chk("flag pulses", 32'h2_0A, {fp[23:0], fl[7:0]});
        @(posedge clk) stage.trip[0] <= 1'b0;
        cyc(2);
        chk("trip gone", 32'h1, {any, ct.contact_two, ct.contact_three});
        cyc(40);
        chk("latch held", 32'h1, ct.contact_three);
        cyc(15);
        chk("latch expired", 32'h0, ct.contact_three);
        chk("coil flag idle", 32'h0, {coil, flag});
        chk("coil last pulse", 32'h3_0A, {cp[23:0], cl[7:0]});
        chk("flag last pulse", 32'h3_0A, {fp[23:0], fl[7:0]});
        for (int i = 1; i < 4; i++) begin
            @(posedge clk) stage.trip[i] <= 1'b1;
            cyc(2);
            chk("stage trip", 32'h3, {any, led.stage_led[i]});
            @(posedge clk) stage.trip <= 4'h0;
            cyc(2);
        end
        @(posedge clk) in1 <= 1'b1;
        cyc(5);
        chk("input one no aux", 32'h0, any);
        @(posedge clk) aux <= 1'b1;
        cyc(5);
        chk("external trip", 32'h3, {any, led.ext_trip_led});
        @(posedge clk) in1 <= 1'b0;
        cyc(5);
        chk("ext led latched", 32'h3, {led.ext_trip_led, ct.contact_three});
        @(posedge clk) in2 <= 1'b1;
        cyc(5);
        chk("latches cleared", 32'h0, {led.ext_trip_led, ct.contact_three});
        @(posedge clk) in2 <= 1'b0;
        mode <= 1'b1;
        cyc(5);
        @(posedge clk) in1 <= 1'b1;
        cyc(5);
        chk("input one other mode", 32'h0, any);
        tally_and_finish();
    end
endmodule

// File: testbench/toil_coil_model.sv
`timescale 1ns/10ps
module toil_coil_model (
    input wire logic clk,
    input wire logic coil,
    input wire logic flag,
    output int coil_pulses,
    output int coil_len,
    output int flag_pulses,
    output int flag_len
);
    int coil_cnt;
    int flag_cnt;
    initial begin
        {coil_pulses, coil_len, flag_pulses, flag_len, coil_cnt, flag_cnt} = '0;
    end
    // Separate stores, so one load never masks the other
    always @(posedge clk) begin
        if (coil) coil_cnt++;
        else if (coil_cnt != 0) begin
            coil_len = coil_cnt;
            coil_pulses++;
            coil_cnt = 0;
        end
        if (flag) flag_cnt++;
        else if (flag_cnt != 0) begin
            flag_len = flag_cnt;
            flag_pulses++;
            flag_cnt = 0;
        end
    end
endmodule

// File: verilog/toil_pkg.sv
package toil_pkg;
    // Timing
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned TRIP_PULSE_MS = 50;
    localparam int unsigned CONTACT1_PULSE_MS = 400;
    localparam int unsigned LATCH_DAYS = 3;
    localparam int unsigned FLASH_HALF_MS = 250;
    localparam int unsigned MS_CYCLES = CLK_HZ / 1000;
    localparam int unsigned TRIP_PULSE_CYC = TRIP_PULSE_MS * MS_CYCLES;
    localparam int unsigned CONTACT1_PULSE_CYC = CONTACT1_PULSE_MS * MS_CYCLES;
    localparam int unsigned FLASH_HALF_CYC = FLASH_HALF_MS * MS_CYCLES;
    localparam longint unsigned LATCH_CYC = 64'(LATCH_DAYS) * 64'd86400 * 64'(CLK_HZ);
    // Stage index
    localparam int STG_PH1 = 0;
    localparam int STG_PH2 = 1;
    localparam int STG_EF1 = 2;
    localparam int STG_EF2 = 3;
    localparam int NUM_STAGES = 4;

    typedef struct packed {
        logic [3:0] start;
        logic [3:0] trip;
    } toil_stage_s;

    typedef struct packed {
        logic [3:0] stage_led;
        logic healthy_led;
        logic ext_trip_led;
    } toil_led_s;

    typedef struct packed {
        logic contact_one;
        logic contact_two;
        logic contact_three;
        logic contact_four;
    } toil_contact_s;

    typedef enum logic [1:0] {
        PULSE_IDLE = 2'b00,
        PULSE_ON = 2'b01,
        PULSE_GAP = 2'b10
    } toil_pulse_e;
endpackage

// File: verilog/toil_trip_output.sv
`timescale 1ns/10ps
//Contract
// RULE1: Stage LED flashes while started, steady once tripped.
// RULE2: Healthy LED lit only when powered and no hardware fault.
// RULE3: External-trip LED lit when trip came via external-trip input.
// RULE4: Trip-coil output pulses 50 ms, repeating until trip criteria reset.
// RULE5: Flag output pulses 50 ms independently, repeating until criteria reset.
// RULE6: Contact one pulses 0.4 s on any trip, not latched.
// RULE7: Contact two follows any trip, not latched.
// RULE8: Contact three latches 3 days on any trip; reset input clears early.
// RULE9: Contact four follows second phase stage start.
// RULE10: Any-trip is OR of four stage trips and external trip.
// RULE11: Logic input one acts as external trip by default.
// RULE12: Logic input two clears latched LEDs and contacts by default.
// RULE13: Default input mapping when switch mode and input-one switch on; code maps only with config mode off and aux switch on.
// RULE14: One fixed flash rate from a divided system clock.
module toil_trip_output
    import toil_pkg::*;
#(
    parameter int unsigned FLASH_CYC = FLASH_HALF_CYC,
    parameter int unsigned PULSE_CYC = TRIP_PULSE_CYC,
    parameter int unsigned C1_CYC = CONTACT1_PULSE_CYC,
    parameter longint unsigned LATCH_CYCLES = LATCH_CYC
) (
    // Clock and reset
    input wire logic I_SYS_CLK,
    input wire logic I_ARST_N,
    // Protection stages
    input wire toil_stage_s I_STAGE,
    // Health
    input wire logic I_CPU_POWERED,
    input wire logic I_HW_FAULT,
    // Logic inputs and switches (asynchronous pins)
    input wire logic I_LOGIC_INPUT_ONE,
    input wire logic I_LOGIC_INPUT_TWO,
    input wire logic I_SWITCH_IO_CONFIG_MODE,
    input wire logic I_SWITCH_INPUT_ONE_AUX,
    // Indications and outputs
    output toil_led_s O_LED,
    output logic O_TRIP_COIL,
    output logic O_FLAG_IND,
    output toil_contact_s O_CONTACT,
    output logic O_ANY_TRIP
);
    typedef struct packed {
        logic [1:0] in1_sync;
        logic [1:0] in2_sync;
        logic [1:0] mode_sync;
        logic [1:0] aux_sync;
        logic [31:0] flash_cnt;
        logic flash_phase;
        toil_pulse_e coil_st;
        logic [31:0] coil_cnt;
        toil_pulse_e flag_st;
        logic [31:0] flag_cnt;
        logic any_trip_d;
        logic [31:0] c1_cnt;
        logic [63:0] latch_cnt;
        logic ext_led;
        logic [3:0] stage_led;
        logic healthy;
        logic any_trip;
        toil_contact_s contact;
    } toil_state_s;

    toil_state_s st_r;
    toil_state_s st_nxt;

    logic default_map;
    logic ext_trip;
    logic reset_latch;
    logic any_trip;

    // Logic inputs and switches used only after two-stage sync
    assign default_map = ~st_r.mode_sync[1] & st_r.aux_sync[1]; // see RULE13
    assign ext_trip = default_map & st_r.in1_sync[1]; // see RULE11
    assign reset_latch = default_map & st_r.in2_sync[1]; // see RULE12
    assign any_trip = (|I_STAGE.trip) | ext_trip; // see RULE10

    always_comb begin
        st_nxt = st_r;
        st_nxt.in1_sync = {st_r.in1_sync[0], I_LOGIC_INPUT_ONE};
        st_nxt.in2_sync = {st_r.in2_sync[0], I_LOGIC_INPUT_TWO};
        st_nxt.mode_sync = {st_r.mode_sync[0], I_SWITCH_IO_CONFIG_MODE};
        st_nxt.aux_sync = {st_r.aux_sync[0], I_SWITCH_INPUT_ONE_AUX};
        st_nxt.any_trip = any_trip;
        st_nxt.any_trip_d = any_trip;
        // Flash divider; slow enough to read by eye
        if (st_r.flash_cnt >= FLASH_CYC - 1) begin // see RULE14
            st_nxt.flash_cnt = '0;
            st_nxt.flash_phase = ~st_r.flash_phase;
        end else begin
            st_nxt.flash_cnt = st_r.flash_cnt + 32'h1;
        end
        for (int i = 0; i < NUM_STAGES; i++) begin
            st_nxt.stage_led[i] = I_STAGE.trip[i] | (I_STAGE.start[i] & st_r.flash_phase); // see RULE1
        end
        st_nxt.healthy = I_CPU_POWERED & ~I_HW_FAULT; // see RULE2
        // External-trip LED latches until reset input; set wins
        if (ext_trip) begin // see RULE3
            st_nxt.ext_led = 1'b1;
        end else if (reset_latch) begin
            st_nxt.ext_led = 1'b0;
        end
        // Trip coil pulse train
        unique case (st_r.coil_st) // see RULE4
            PULSE_IDLE: begin
                st_nxt.coil_cnt = '0;
                if (any_trip) begin
                    st_nxt.coil_st = PULSE_ON;
                end
            end
            PULSE_ON: begin
                st_nxt.coil_cnt = st_r.coil_cnt + 32'h1;
                if (st_r.coil_cnt >= PULSE_CYC - 1) begin
                    st_nxt.coil_cnt = '0;
                    st_nxt.coil_st = PULSE_GAP;
                end
            end
            PULSE_GAP: begin
                st_nxt.coil_cnt = '0;
                st_nxt.coil_st = any_trip ? PULSE_ON : PULSE_IDLE;
            end
            default: begin
                st_nxt.coil_st = PULSE_IDLE;
            end
        endcase
        // Flag indicator, own timer
        unique case (st_r.flag_st) // see RULE5
            PULSE_IDLE: begin
                st_nxt.flag_cnt = '0;
                if (any_trip) begin
                    st_nxt.flag_st = PULSE_ON;
                end
            end
            PULSE_ON: begin
                st_nxt.flag_cnt = st_r.flag_cnt + 32'h1;
                if (st_r.flag_cnt >= PULSE_CYC - 1) begin
                    st_nxt.flag_cnt = '0;
                    st_nxt.flag_st = PULSE_GAP;
                end
            end
            PULSE_GAP: begin
                st_nxt.flag_cnt = '0;
                st_nxt.flag_st = any_trip ? PULSE_ON : PULSE_IDLE;
            end
            default: begin
                st_nxt.flag_st = PULSE_IDLE;
            end
        endcase
        // Contact one: fixed pulse on rising any-trip
        if (any_trip & ~st_r.any_trip_d) begin // see RULE6
            st_nxt.c1_cnt = 32'(C1_CYC);
        end else if (st_r.c1_cnt != '0) begin
            st_nxt.c1_cnt = st_r.c1_cnt - 32'h1;
        end
        st_nxt.contact.contact_one = (st_nxt.c1_cnt != '0);
        st_nxt.contact.contact_two = any_trip; // see RULE7
        // Contact three: timed latch, set beats reset
        if (any_trip) begin // see RULE8
            st_nxt.latch_cnt = LATCH_CYCLES;
        end else if (reset_latch) begin
            st_nxt.latch_cnt = '0;
        end else if (st_r.latch_cnt != '0) begin
            st_nxt.latch_cnt = st_r.latch_cnt - 64'h1;
        end
        st_nxt.contact.contact_three = (st_nxt.latch_cnt != '0);
        st_nxt.contact.contact_four = I_STAGE.start[STG_PH2]; // see RULE9
    end

    always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign O_LED.stage_led = st_r.stage_led;
    assign O_LED.healthy_led = st_r.healthy;
    assign O_LED.ext_trip_led = st_r.ext_led;
    assign O_TRIP_COIL = (st_r.coil_st == PULSE_ON);
    assign O_FLAG_IND = (st_r.flag_st == PULSE_ON);
    assign O_CONTACT = st_r.contact;
    assign O_ANY_TRIP = st_r.any_trip;

    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_ARST_N);

    a_stage_led_trip: assert property (I_STAGE.trip[0] |=> O_LED.stage_led[0]) // see RULE1
        else $error("tripped stage LED not lit");
    a_healthy_led: assert property ($past(I_ARST_N) |-> O_LED.healthy_led == $past(I_CPU_POWERED & ~I_HW_FAULT)) // see RULE2
        else $error("healthy LED wrong");
    a_ext_led_set: assert property (ext_trip |=> O_LED.ext_trip_led) // see RULE3
        else $error("external trip LED not set");
    a_coil_pulse_start: assert property ($rose(any_trip) && st_r.coil_st == PULSE_IDLE |=> O_TRIP_COIL) // see RULE4
        else $error("coil pulse did not start");
    a_flag_gap_end: assert property ($fell(O_FLAG_IND) ##1 any_trip |=> O_FLAG_IND) // see RULE5
        else $error("flag pulse did not repeat");
    a_contact_one_on: assert property ($rose(any_trip) |=> O_CONTACT.contact_one [*8]) // see RULE6
        else $error("contact one pulse too short");
    a_contact_two: assert property (any_trip |=> O_CONTACT.contact_two && O_ANY_TRIP) // see RULE7
        else $error("contact two not following trip");
    a_contact_three_rst: assert property (!any_trip && reset_latch |=> !O_CONTACT.contact_three) // see RULE8
        else $error("contact three not cleared");
    a_contact_four: assert property ($past(I_ARST_N) |-> O_CONTACT.contact_four == $past(I_STAGE.start[STG_PH2])) // see RULE9
        else $error("contact four wrong");
    a_ext_mapping: assert property (st_r.in1_sync[1] && default_map |=> O_ANY_TRIP && O_LED.ext_trip_led) // see RULE11
        else $error("input one not mapped to trip");

    c_ext_trip: cover property (ext_trip ##1 O_LED.ext_trip_led);
    c_coil_repeat: cover property ($fell(O_TRIP_COIL) ##1 O_TRIP_COIL);
    c_latch_reset: cover property (O_CONTACT.contact_three ##1 reset_latch ##1 !O_CONTACT.contact_three);
endmodule
